// ==== logic/gpcfg_params.svh ====
// Purpose: Offsets, field positions, masks and reset values of the pin block.
// Assumes: Register indices are word indices; byte address is four times the index.
// Notes:   Definitions only.
`ifndef GPCFG_PARAMS_SVH
`define GPCFG_PARAMS_SVH
`define GPCFG_IDX_CTRL    16'hc006
`define GPCFG_IDX_OUT_LO  16'hc01e
`define GPCFG_IDX_IN_LO   16'hc020
`define GPCFG_IDX_DIR_LO  16'hc022
`define GPCFG_IDX_OUT_HI  16'hc024
`define GPCFG_IDX_IN_HI   16'hc026
`define GPCFG_IDX_DIR_HI  16'hc028
`define GPCFG_IDX_EV_STAT 16'hc02a
`define GPCFG_IDX_EV_EN   16'hc02c
`define GPCFG_IDX_EV_CLR  16'hc02e
`define GPCFG_CTRL_WP     15
`define GPCFG_CTRL_ALTSS  11
`define GPCFG_CTRL_MODE_H 10
`define GPCFG_CTRL_MODE_L 8
`define GPCFG_CTRL_FSS    7
`define GPCFG_CTRL_SPI    5
`define GPCFG_CTRL_POL    1
`define GPCFG_CTRL_EN     0
`define GPCFG_CTRL_WMASK  16'h8fa3
`define GPCFG_HI_MASK     16'he1f8
`define GPCFG_RST_REG     16'h0000
`define GPCFG_EV_EDGE     0
`define GPCFG_EV_WPROT    1
`define GPCFG_EV_W        2
`define GPCFG_PIN_IRQ     24
`define GPCFG_PIN_SS      9
`define GPCFG_PIN_SS_ALT  15
`endif

// ==== logic/gpcfg_pkg.sv ====
// Purpose: Types of the pin configuration and data block.
// Assumes: Constants come from gpcfg_params.svh.
// Notes:   All state of the top module is one packed struct.
`include "gpcfg_params.svh"
package gpcfg_pkg;
  typedef enum logic [2:0] {
    GPCFG_MODE_GPIO = 3'b000,
    GPCFG_MODE_HOST = 3'b101,
    GPCFG_MODE_SCAN = 3'b110
  } gpcfg_mode_type;

  typedef struct packed {
    logic [15:0]            ctrl;
    logic [15:0]            out_lo;
    logic [15:0]            dir_lo;
    logic [15:0]            out_hi;
    logic [15:0]            dir_hi;
    logic [`GPCFG_EV_W-1:0] ev_status;
    logic [`GPCFG_EV_W-1:0] ev_enable;
    logic                   edge_prev;
    logic                   pready;
    logic                   pslverr;
    logic [31:0]            prdata;
    logic [31:0]            pin_out;
    logic [31:0]            pin_oe_n;
    logic                   irq;
    logic [3:0]             fss_in;
    logic [3:0]             spi_in;
    logic                   ss_in;
  } gpcfg_state_type;
endpackage

// ==== logic/gpcfg_sync.sv ====
// Purpose: Two flip-flop synchroniser for a vector of pin levels.
// Assumes: Each bit is an independent level.
// Notes:   Only the second stage is visible outside.
module gpcfg_sync #(
  parameter int WIDTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_r <= '0;
      q_o    <= '0;
    end
    else
    begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule

// ==== logic/gpcfg_top.sv ====
// Purpose: Pin configuration, routing and data registers with an APB slave.
// Assumes: Single clock clk_i at 20 MHz, synchronous active high reset rst_i.
// Notes:   Pins are split into output, active low output enable and input.
// Functional notes
// - Plain mode, alternate select on and SPI routed: slave select from pin 15; SPI routed only: pin 9; else high.
// - Mode field 10:8 picks plain pins 000, host port 101, scan 110.
// - In plain mode, fast serial routing bit places the serial port on pins 15..12.
// - In plain mode, SPI routing bit places the SPI port on pins 11..8.
// - Alternate select wins over pin 15 use; pin 9 goes back to plain use, SPI pins 11, 10 and 8 stay put.
// - Polarity bit picks rising edge when one, falling edge when zero.
// - Pin interrupt needs control enable bit and the event enable bit.
// - Output data reads return last written value with reserved high bits zero, not pin levels.
// - Output bit one drives pin high, zero drives low, when output.
// - Low output maps pins 15..0; high maps 31..29, 24, 23..19.
// - Input bits show sampled pin levels and are read only.
// - Input registers use the same bit positions as output registers.
// - Direction one makes the pin an output, zero an input.
// - Write protect freezes control bits 15..8 until reset.
`include "gpcfg_params.svh"
module gpcfg_top #(
  parameter int ADDR_W = 20
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic [31:0]       gpio_in_i,
  output logic      [31:0]       gpio_out_o,
  output logic      [31:0]       gpio_oe_n_o,
  input  wire logic [3:0]        fast_serial_port_out_i,
  input  wire logic [3:0]        fast_serial_port_oe_i,
  output logic      [3:0]        fast_serial_port_in_o,
  input  wire logic [3:0]        spi_out_i,
  input  wire logic [3:0]        spi_oe_i,
  output logic      [3:0]        spi_in_o,
  output logic                   spi_slave_select_in_o,
  output logic                   irq_o
);
  gpcfg_pkg::gpcfg_state_type st_r;
  gpcfg_pkg::gpcfg_state_type st_nxt;
  logic [31:0]                pin_s;
  logic [ADDR_W-3:0]          word;
  logic                       hit;
  logic [31:0]                rdata;
  logic                       wr_en;
  logic                       setup;
  logic [15:0]                wdata;
  logic [15:0]                ctrl_new;
  logic                       is_gpio;
  logic                       alt_ss;
  logic                       pin_edge;
  logic [`GPCFG_EV_W-1:0]     ev_set;
  logic [`GPCFG_EV_W-1:0]     ev_clr;

  ////////////////////////////////////////////////////////////////////////////////////
  gpcfg_sync #(
    .WIDTH (32)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (gpio_in_i),
    .q_o   (pin_s)
  );

  ////////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_nxt = st_r;
    word   = paddr_i[ADDR_W-1:2];
    wdata  = pwdata_i[15:0];
    hit    = 1'b0;
    rdata  = '0;
    ev_set = '0;
    ev_clr = '0;
    setup  = psel_i & ~penable_i & ~st_r.pready;
    wr_en  = psel_i & penable_i & st_r.pready & pwrite_i & ~st_r.pslverr;
    // A locked control register keeps its upper byte.
    ctrl_new = wdata & `GPCFG_CTRL_WMASK;
    if (st_r.ctrl[`GPCFG_CTRL_WP])
    begin
      ctrl_new[15:8] = st_r.ctrl[15:8];
    end
    if (paddr_i[1:0] != 2'b00)
    begin
      hit = 1'b0;
    end
    else if (word == (ADDR_W-2)'(`GPCFG_IDX_CTRL))
    begin
      hit   = 1'b1;
      rdata = {16'h0000, st_r.ctrl};
      if (wr_en)
      begin
        st_nxt.ctrl = ctrl_new;
        if (st_r.ctrl[`GPCFG_CTRL_WP] && (wdata[15:8] != st_r.ctrl[15:8]))
        begin
          ev_set[`GPCFG_EV_WPROT] = 1'b1;
        end
      end
    end
    else if (word == (ADDR_W-2)'(`GPCFG_IDX_OUT_LO))
    begin
      hit   = 1'b1;
      rdata = {16'h0000, st_r.out_lo};
      if (wr_en)
      begin
        st_nxt.out_lo = wdata;
      end
    end
    else if (word == (ADDR_W-2)'(`GPCFG_IDX_IN_LO))
    begin
      hit   = 1'b1;
      rdata = {16'h0000, pin_s[15:0]};
    end
    else if (word == (ADDR_W-2)'(`GPCFG_IDX_DIR_LO))
    begin
      hit   = 1'b1;
      rdata = {16'h0000, st_r.dir_lo};
      if (wr_en)
      begin
        st_nxt.dir_lo = wdata;
      end
    end
    else if (word == (ADDR_W-2)'(`GPCFG_IDX_OUT_HI))
    begin
      hit   = 1'b1;
      rdata = {16'h0000, st_r.out_hi};
      if (wr_en)
      begin
        st_nxt.out_hi = wdata & `GPCFG_HI_MASK;
      end
    end
    else if (word == (ADDR_W-2)'(`GPCFG_IDX_IN_HI))
    begin
      hit   = 1'b1;
      rdata = {16'h0000, pin_s[31:16] & `GPCFG_HI_MASK};
    end
    else if (word == (ADDR_W-2)'(`GPCFG_IDX_DIR_HI))
    begin
      hit   = 1'b1;
      rdata = {16'h0000, st_r.dir_hi};
      if (wr_en)
      begin
        st_nxt.dir_hi = wdata & `GPCFG_HI_MASK;
      end
    end
    else if (word == (ADDR_W-2)'(`GPCFG_IDX_EV_STAT))
    begin
      hit   = 1'b1;
      rdata = {30'h00000000, st_r.ev_status};
    end
    else if (word == (ADDR_W-2)'(`GPCFG_IDX_EV_EN))
    begin
      hit   = 1'b1;
      rdata = {30'h00000000, st_r.ev_enable};
      if (wr_en)
      begin
        st_nxt.ev_enable = wdata[`GPCFG_EV_W-1:0];
      end
    end
    else if (word == (ADDR_W-2)'(`GPCFG_IDX_EV_CLR))
    begin
      hit = 1'b1;
      if (wr_en)
      begin
        ev_clr = wdata[`GPCFG_EV_W-1:0];
      end
    end

    // The slave answers in the first access cycle.
    if (setup)
    begin
      st_nxt.pready  = 1'b1;
      st_nxt.prdata  = hit ? rdata : 32'h00000000;
      st_nxt.pslverr = ~hit;
    end
    else if (st_r.pready)
    begin
      st_nxt.pready  = 1'b0;
      st_nxt.pslverr = 1'b0;
    end

    // Pin interrupt edge on the synchronised level.
    st_nxt.edge_prev = pin_s[`GPCFG_PIN_IRQ];
    if (st_r.ctrl[`GPCFG_CTRL_POL])
    begin
      pin_edge = pin_s[`GPCFG_PIN_IRQ] & ~st_r.edge_prev;
    end
    else
    begin
      pin_edge = ~pin_s[`GPCFG_PIN_IRQ] & st_r.edge_prev;
    end
    if (pin_edge && st_r.ctrl[`GPCFG_CTRL_EN])
    begin
      ev_set[`GPCFG_EV_EDGE] = 1'b1;
    end
    // A new event wins over a clear in the same cycle.
    st_nxt.ev_status = (st_r.ev_status & ~ev_clr) | ev_set;
    st_nxt.irq       = |(st_r.ev_status & st_r.ev_enable);

    // Plain pin drive from data and direction registers.
    st_nxt.pin_out  = {st_r.out_hi & `GPCFG_HI_MASK, st_r.out_lo};
    st_nxt.pin_oe_n = ~{st_r.dir_hi & `GPCFG_HI_MASK, st_r.dir_lo};
    is_gpio = (st_r.ctrl[`GPCFG_CTRL_MODE_H:`GPCFG_CTRL_MODE_L] == gpcfg_pkg::GPCFG_MODE_GPIO);
    alt_ss  = st_r.ctrl[`GPCFG_CTRL_SPI] & st_r.ctrl[`GPCFG_CTRL_ALTSS];
    if (!is_gpio)
    begin
      // Host port and scan modes own pins 15..0 and 24..19; this block lets go of them.
      st_nxt.pin_oe_n[15:0]  = 16'hffff;
      st_nxt.pin_oe_n[24:19] = 6'h3f;
    end
    else
    begin
      if (st_r.ctrl[`GPCFG_CTRL_FSS])
      begin
        st_nxt.pin_out[15:12]  = fast_serial_port_out_i;
        st_nxt.pin_oe_n[15:12] = ~fast_serial_port_oe_i;
      end
      if (st_r.ctrl[`GPCFG_CTRL_SPI])
      begin
        st_nxt.pin_out[11:8]  = spi_out_i;
        st_nxt.pin_oe_n[11:8] = ~spi_oe_i;
      end
      if (alt_ss)
      begin
        // Pin 9 goes back to plain use; pin 15 becomes the select input.
        st_nxt.pin_out[`GPCFG_PIN_SS]      = st_r.out_lo[`GPCFG_PIN_SS];
        st_nxt.pin_oe_n[`GPCFG_PIN_SS]     = ~st_r.dir_lo[`GPCFG_PIN_SS];
        st_nxt.pin_oe_n[`GPCFG_PIN_SS_ALT] = 1'b1;
      end
    end
    st_nxt.fss_in = pin_s[15:12];
    st_nxt.spi_in = pin_s[11:8];
    if (is_gpio && alt_ss)
    begin
      st_nxt.ss_in = pin_s[`GPCFG_PIN_SS_ALT];
    end
    else if (is_gpio && st_r.ctrl[`GPCFG_CTRL_SPI])
    begin
      st_nxt.ss_in = pin_s[`GPCFG_PIN_SS];
    end
    else
    begin
      st_nxt.ss_in = 1'b1;
    end

    if (rst_i)
    begin
      st_nxt          = '0;
      st_nxt.pin_oe_n = '1;
      st_nxt.ss_in    = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    st_r <= st_nxt;
  end

  assign prdata_o              = st_r.prdata;
  assign pready_o              = st_r.pready;
  assign pslverr_o             = st_r.pslverr;
  assign gpio_out_o            = st_r.pin_out;
  assign gpio_oe_n_o           = st_r.pin_oe_n;
  assign fast_serial_port_in_o = st_r.fss_in;
  assign spi_in_o              = st_r.spi_in;
  assign spi_slave_select_in_o = st_r.ss_in;
  assign irq_o                 = st_r.irq;

  ////////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_SS_ALT: assert property (is_gpio && alt_ss |=>
    spi_slave_select_in_o == $past(pin_s[15]))
    else $error("Slave select not taken from pin 15.");
  AST_SS_MAIN: assert property (is_gpio && st_r.ctrl[5] && !st_r.ctrl[11] |=>
    spi_slave_select_in_o == $past(pin_s[9]))
    else $error("Slave select not taken from pin 9.");
  AST_MODE_RELEASE: assert property (!is_gpio |=>
    (&gpio_oe_n_o[15:0]) && (&gpio_oe_n_o[24:19]))
    else $error("Pins driven outside plain mode.");
  AST_FSS_ROUTE: assert property (is_gpio && st_r.ctrl[7] |=>
    gpio_out_o[14:12] == $past(fast_serial_port_out_i[2:0]))
    else $error("Fast serial port not on its pins.");
  AST_SPI_ROUTE: assert property (is_gpio && st_r.ctrl[5] |=>
    gpio_out_o[11:10] == $past(spi_out_i[3:2]) && gpio_oe_n_o[8] == !$past(spi_oe_i[0]))
    else $error("SPI port not on its pins.");
  AST_ALT_PIN15: assert property (is_gpio && alt_ss |=> gpio_oe_n_o[15])
    else $error("Pin 15 driven while used as select input.");
  AST_RISE_EVENT: assert property (st_r.ctrl[0] && st_r.ctrl[1] && pin_s[24] &&
    !st_r.edge_prev |=> st_r.ev_status[0])
    else $error("Rising edge event lost.");
  AST_NO_EVENT: assert property (!st_r.ctrl[0] && !st_r.ev_status[0] |=>
    !st_r.ev_status[0])
    else $error("Pin event set while disabled.");
  AST_IRQ_GATE: assert property (!st_r.ev_enable[0] && !st_r.ev_enable[1] |=> !irq_o)
    else $error("Interrupt raised with events masked.");
  AST_READBACK: assert property (setup && word == (ADDR_W-2)'(`GPCFG_IDX_OUT_LO) &&
    paddr_i[1:0] == 2'b00 |=> pready_o && prdata_o[15:0] == $past(st_r.out_lo))
    else $error("Output register read not the stored value.");
  AST_PIN_DRIVE: assert property (is_gpio && st_r.dir_lo[0] |=>
    !gpio_oe_n_o[0] && gpio_out_o[0] == $past(st_r.out_lo[0]))
    else $error("Pin 0 not driven from its data bit.");
  AST_HI_MAP: assert property (is_gpio && st_r.dir_hi[8] |=>
    !gpio_oe_n_o[24] && gpio_out_o[24] == $past(st_r.out_hi[8]))
    else $error("Upper bit 8 not on pin 24.");
  AST_IN_READ: assert property (setup && word == (ADDR_W-2)'(`GPCFG_IDX_IN_HI) &&
    paddr_i[1:0] == 2'b00 |=> prdata_o[15:0] == ($past(pin_s[31:16]) & 16'he1f8))
    else $error("Upper input read wrong.");
  AST_DIR_IN: assert property (st_r.dir_lo[1] == 1'b0 |=> gpio_oe_n_o[1])
    else $error("Input pin driven.");
  AST_WPROT: assert property (st_r.ctrl[15] |=> $stable(st_r.ctrl[15:8]))
    else $error("Locked control byte changed.");
  AST_RESET: assert property (disable iff (1'b0) rst_i |=>
    st_r.ctrl == 16'h0000 && (&gpio_oe_n_o) && !irq_o)
    else $error("Reset state wrong.");
  AST_RSVD: assert property ((st_r.out_hi & ~16'he1f8) == 16'h0000 &&
    (st_r.dir_hi & ~16'he1f8) == 16'h0000)
    else $error("Reserved upper bits hold ones.");

  COV_ALT_SS: cover property (is_gpio && alt_ss ##1 spi_slave_select_in_o == 1'b0);
  COV_IRQ: cover property (st_r.ev_status[0] ##1 irq_o);
  COV_LOCK: cover property (st_r.ctrl[15] && wr_en);
  COV_ERR: cover property (pready_o && pslverr_o);
endmodule

// ==== test/gpcfg_pins.sv ====
// Purpose: Model of the pins and the parts wired to them outside the block.
// Assumes: A pin the block drives shows the block's level; others show the outside level.
// Notes:   The outside level comes from the bench.
module gpcfg_pins (
  input  wire logic [31:0] out_i,
  input  wire logic [31:0] oe_n_i,
  input  wire logic [31:0] ext_i,
  output logic      [31:0] lvl_o
);
  timeunit 1ns;
  timeprecision 1ns;
  assign lvl_o = (out_i & ~oe_n_i) | (ext_i & oe_n_i);
endmodule

// ==== test/test_gpio_pin_config_and_data.sv ====
// Purpose: Self-checking bench of the pin configuration and data block.
// Assumes: Each register sits at a byte address four times its index.
// Notes:   Pin levels loop back through the pin model.
`include "gpcfg_params.svh"
module test_gpio_pin_config_and_data;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] CT = `GPCFG_IDX_CTRL, OL = `GPCFG_IDX_OUT_LO, IL = `GPCFG_IDX_IN_LO,
    DL = `GPCFG_IDX_DIR_LO, OH = `GPCFG_IDX_OUT_HI, IH = `GPCFG_IDX_IN_HI,
    DH = `GPCFG_IDX_DIR_HI, ST = `GPCFG_IDX_EV_STAT, EN = `GPCFG_IDX_EV_EN,
    CL = `GPCFG_IDX_EV_CLR;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [19:0] paddr_i = 20'h00000;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] ext = 32'h0;
  logic [3:0]  fast_serial_port_out_i = 4'h0;
  logic [3:0]  fast_serial_port_oe_i = 4'h0;
  logic [3:0]  spi_out_i = 4'h0;
  logic [3:0]  spi_oe_i = 4'h0;
  logic [31:0] prdata_o, gpio_in_i, gpio_out_o, gpio_oe_n_o, d;
  logic [3:0]  fast_serial_port_in_o, spi_in_o;
  logic        pready_o, pslverr_o, spi_slave_select_in_o, irq_o, e;
  logic [15:0] regs [10] = '{CT, OL, IL, DL, OH, IH, DH, ST, EN, CL};
  int          failures = 0;
  int          checks = 0;
  always #25 clk_i = ~clk_i;
  gpcfg_top dut (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .gpio_in_i, .gpio_out_o, .gpio_oe_n_o,
    .fast_serial_port_out_i, .fast_serial_port_oe_i, .fast_serial_port_in_o,
    .spi_out_i, .spi_oe_i, .spi_in_o, .spi_slave_select_in_o, .irq_o);
  gpcfg_pins pins (.out_i(gpio_out_o), .oe_n_i(gpio_oe_n_o), .ext_i(ext), .lvl_o(gpio_in_i));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] v,
                      output logic [31:0] r, output logic x);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= {2'b00, a, 2'b00};
    pwdata_i <= {16'h0000, v};
    @(posedge clk_i);
    penable_i <= 1'b1;
    do
    begin
      @(posedge clk_i);
    end
    while (pready_o !== 1'b1);
    r = prdata_o;
    x = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    xfer(1'b1, a, v, d, e);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 16'h0000, d, e);
    chk(d, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(8);
    rst_i <= 1'b0;
    cyc(1);
    chk(gpio_oe_n_o, 32'hffffffff);
    chk({30'h0, irq_o, spi_slave_select_in_o}, 32'h1);
    foreach (regs[k]) rd(regs[k], 32'h0);
    xfer(1'b0, 16'hc008, 16'h0000, d, e);
    chk({e, d[30:0]}, 32'h80000000);
    wr(DL, 16'hffff);
    wr(OL, 16'ha5c3);
    cyc(2);
    chk({gpio_oe_n_o[15:0], gpio_out_o[15:0]}, 32'h0000a5c3);
    cyc(2);
    rd(IL, 32'h0000a5c3);
    ext <= 32'h00003c5a;
    wr(DL, 16'h0000);
    wr(IL, 16'hffff);
    cyc(3);
    rd(IL, 32'h00003c5a);
    rd(OL, 32'h0000a5c3);
    wr(DH, 16'hffff);
    wr(OH, 16'hffff);
    cyc(2);
    rd(OH, 32'h0000e1f8);
    rd(DH, 32'h0000e1f8);
    chk({gpio_out_o[31:16], ~gpio_oe_n_o[31:16]}, 32'he1f8e1f8);
    wr(DH, 16'h0000);
    ext <= 32'hffff0000;
    cyc(3);
    rd(IH, 32'h0000e1f8);
    rd(ST, 32'h0);
    ext <= 32'h0;
    fast_serial_port_oe_i <= 4'hf;
    fast_serial_port_out_i <= 4'ha;
    spi_oe_i <= 4'hd;
    spi_out_i <= 4'h5;
    wr(CT, 16'h00a0);
    cyc(2);
    chk({gpio_out_o[15:8] & ~gpio_oe_n_o[15:8], gpio_oe_n_o[15:8]}, 32'ha502);
    ext <= 32'h00000200;
    cyc(4);
    chk({fast_serial_port_in_o, spi_in_o, 23'h0, spi_slave_select_in_o}, 32'ha7000001);
    ext <= 32'h0;
    cyc(4);
    chk({31'h0, spi_slave_select_in_o}, 32'h0);
    wr(CT, 16'h08a0);
    ext <= 32'h00008000;
    cyc(4);
    chk({29'h0, spi_slave_select_in_o, gpio_oe_n_o[15], gpio_oe_n_o[8]}, 32'h6);
    ext <= 32'h0;
    cyc(4);
    chk({31'h0, spi_slave_select_in_o}, 32'h0);
    wr(DL, 16'hffff);
    wr(CT, 16'h0500);
    cyc(2);
    chk({16'h0, gpio_oe_n_o[15:0]}, 32'h0000ffff);
    rd(CT, 32'h00000500);
    wr(CT, 16'h0000);
    cyc(2);
    chk({16'h0, gpio_oe_n_o[15:0]}, 32'h0);
    wr(DL, 16'h0000);
    wr(EN, 16'h0001);
    wr(CT, 16'h0003);
    ext <= 32'h01000000;
    cyc(8);
    rd(ST, 32'h1);
    chk({31'h0, irq_o}, 32'h1);
    wr(CL, 16'h0001);
    cyc(3);
    rd(ST, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    ext <= 32'h0;
    cyc(8);
    rd(ST, 32'h0);
    wr(CT, 16'h0001);
    ext <= 32'h01000000;
    cyc(8);
    rd(ST, 32'h0);
    wr(EN, 16'h0000);
    ext <= 32'h0;
    cyc(8);
    rd(ST, 32'h1);
    chk({31'h0, irq_o}, 32'h0);
    wr(CL, 16'h0001);
    wr(CT, 16'h0000);
    wr(EN, 16'h0001);
    ext <= 32'h01000000;
    cyc(8);
    rd(ST, 32'h0);
    wr(CT, 16'h8000);
    wr(CT, 16'h0503);
    rd(CT, 32'h00008003);
    rd(ST, 32'h2);
    rst_i <= 1'b1;
    cyc(2);
    rst_i <= 1'b0;
    cyc(1);
    rd(CT, 32'h0);
    test_done();
  end
  initial
  begin
    cyc(20000);
    failures++;
    test_done();
  end
endmodule
